// ### common/port_d_pkg.sv
// package: register map, field layout and reset values of the input port
package port_d_pkg;
  // byte offsets on the register bus
  localparam logic [11:0] OFS_PIN_INPUT_VALUE = 12'h3FC;
  localparam logic [11:0] OFS_FUNCTION_SELECT_ONE = 12'h424;
  localparam logic [11:0] OFS_FUNCTION_SELECT_TWO = 12'h428;
  localparam logic [11:0] OFS_IRQ_SENSITIVITY_SELECT = 12'h804;
  localparam logic [11:0] OFS_IRQ_BOTH_EDGE_SELECT = 12'h808;
  localparam logic [11:0] OFS_IRQ_POLARITY_SELECT = 12'h80C;
  localparam logic [11:0] OFS_IRQ_ENABLE_MASK = 12'h810;
  localparam logic [11:0] OFS_IRQ_RAW_FLAGS = 12'h814;
  localparam logic [11:0] OFS_IRQ_MASKED_FLAGS = 12'h818;
  localparam logic [11:0] OFS_IRQ_CLEAR_STROBE = 12'h81C;
  // the data register window spans address bits 9..2; mask lines are address bits 9..6
  localparam logic [11:0] DATA_WINDOW_MASK = 12'hC03;
  localparam logic [11:0] DATA_WINDOW_BASE = 12'h000;
  localparam int MASK_ADDR_LSB = 2;
  // field positions
  localparam int ALT_LSB = 4;
  localparam int IRQ_LSB = 6;
  // reset values
  localparam logic [3:0] FSEL_ONE_RESET = 4'hF;
  localparam logic [3:0] FSEL_TWO_RESET = 4'h0;
  localparam logic [1:0] IRQ_CFG_RESET = 2'h0;
  localparam logic [3:0] PIN_SYNC_RESET = 4'hF;
  localparam logic [7:0] WIDE_PIN_RESET = 8'hFF;
  // pin function per upper pin
  typedef enum logic [1:0] {
    PIN_GPIO,
    PIN_ALT_CONVERTER,
    PIN_ALT_TOUCH,
    PIN_PROHIBITED
  } pin_func_t;
  // interrupt configuration of the two interrupt pins
  typedef struct packed {
    logic [1:0] sens;
    logic [1:0] both;
    logic [1:0] pol;
    logic [1:0] en;
  } irq_cfg_t;
  // classic wishbone request
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [11:0] adr;
    logic [31:0] dat;
  } wb_req_t;
endpackage

// ### hdl/port_d_input_irq.sv
// input port with alternate functions and two external interrupt lines
//
// The Wishbone register port was chosen for this implementation.
`timescale 1ns/10ps
module port_d_input_irq
  import port_d_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // classic wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  // package pins
  input wire logic [7:0] pin_i,
  // alternate function routing
  output logic [3:0] converter_channels_upper_o,
  output logic [3:0] converter_route_en_o,
  output logic touch_y_plus_o,
  output logic touch_x_plus_o,
  output logic touch_y_minus_o,
  output logic touch_x_minus_o,
  output logic [3:0] touch_route_en_o,
  output logic touch_screen_irq_o,
  // interrupt lines
  output logic external_irq_line_one_o,
  output logic external_irq_line_two_o,
  output logic irq_o
);

  // bundled request for decoding
  wb_req_t req;
  assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, sel: wb_sel_i,
                 adr: wb_adr_i, dat: wb_dat_i};

  // registers
  logic [7:0] pin_meta_reg;
  logic [7:0] pin_sync_reg;
  logic [1:0] pin_prev_reg;
  logic [3:0] fsel_one_reg;
  logic [3:0] fsel_two_reg;
  irq_cfg_t cfg_reg;
  logic [1:0] edge_flag_reg;
  logic ack_reg;
  logic err_reg;
  logic [31:0] rdata_reg;

  // address decode
  wire access_w = req.cyc && req.stb && !ack_reg && !err_reg;
  wire wr_w = access_w && req.we && req.sel[0];
  wire hit_data = (req.adr & DATA_WINDOW_MASK) == DATA_WINDOW_BASE;
  wire hit_fs1 = req.adr == OFS_FUNCTION_SELECT_ONE;
  wire hit_fs2 = req.adr == OFS_FUNCTION_SELECT_TWO;
  wire hit_sens = req.adr == OFS_IRQ_SENSITIVITY_SELECT;
  wire hit_both = req.adr == OFS_IRQ_BOTH_EDGE_SELECT;
  wire hit_pol = req.adr == OFS_IRQ_POLARITY_SELECT;
  wire hit_en = req.adr == OFS_IRQ_ENABLE_MASK;
  wire hit_raw = req.adr == OFS_IRQ_RAW_FLAGS;
  wire hit_mis = req.adr == OFS_IRQ_MASKED_FLAGS;
  wire hit_clr = req.adr == OFS_IRQ_CLEAR_STROBE;
  wire hit_any = hit_data | hit_fs1 | hit_fs2 | hit_sens | hit_both | hit_pol
                 | hit_en | hit_raw | hit_mis | hit_clr;

  // per-pin function decode, pins 7..4
  pin_func_t func_w [4];
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_func
      // 00 input, 10 alt one, 01 alt two, 11 prohibited
      assign func_w[g] = fsel_one_reg[g] ? (fsel_two_reg[g] ? PIN_PROHIBITED
                                                             : PIN_ALT_CONVERTER)
                                         : (fsel_two_reg[g] ? PIN_ALT_TOUCH
                                                             : PIN_GPIO);
      // converter while alt one and no interrupt on that pin
      assign converter_route_en_o[g] = (func_w[g] == PIN_ALT_CONVERTER)
          && !(g >= 2 && cfg_reg.en[g-2 < 0 ? 0 : g-2]);
      assign converter_channels_upper_o[g] = converter_route_en_o[g] & pin_sync_reg[ALT_LSB+g];
      assign touch_route_en_o[g] = func_w[g] == PIN_ALT_TOUCH;
    end
  endgenerate

  // touch lines: 7 y plus, 6 x plus, 5 y minus, 4 x minus
  assign touch_y_plus_o = touch_route_en_o[3] & pin_sync_reg[7];
  assign touch_x_plus_o = touch_route_en_o[2] & pin_sync_reg[6];
  assign touch_y_minus_o = touch_route_en_o[1] & pin_sync_reg[5];
  assign touch_x_minus_o = touch_route_en_o[0] & pin_sync_reg[4];

  // interrupt sources: only pins 7 and 6 feed detection
  wire [1:0] src_w = pin_sync_reg[7:6];
  wire [1:0] prev_w = pin_prev_reg;
  wire [1:0] rise_w = src_w & ~prev_w;
  wire [1:0] fall_w = ~src_w & prev_w;
  // edge detection per line, both-edge or polarity edge
  wire [1:0] edge_det_w = (cfg_reg.both & (rise_w | fall_w))
                        | (~cfg_reg.both & cfg_reg.pol & rise_w)
                        | (~cfg_reg.both & ~cfg_reg.pol & fall_w);
  // level detection follows the pin, not latched
  wire [1:0] level_det_w = ~(src_w ^ cfg_reg.pol);
  wire [1:0] clr_w = (wr_w && hit_clr) ? req.dat[IRQ_LSB+1:IRQ_LSB] : 2'h0;
  // set wins over clear
  wire [1:0] edge_flag_next = (edge_flag_reg & ~clr_w) | (edge_det_w & ~cfg_reg.sens);
  // per line: level result when level-sensitive, latched edge otherwise
  wire [1:0] raw_mix_w = (cfg_reg.sens & level_det_w) | (~cfg_reg.sens & edge_flag_reg);
  wire [1:0] mis_w = raw_mix_w & cfg_reg.en;

  // line one from pin 6, line two from pin 7, each gated by enable
  assign external_irq_line_one_o = mis_w[0] & (func_w[2] == PIN_GPIO);
  assign external_irq_line_two_o = mis_w[1] & (func_w[3] == PIN_GPIO);
  assign touch_screen_irq_o = mis_w[0] & (func_w[2] == PIN_ALT_TOUCH);
  assign irq_o = |mis_w;

  // data register read, masked by address lines
  wire [3:0] data_mask_w = req.adr[MASK_ADDR_LSB+7:MASK_ADDR_LSB+4];
  wire [7:0] data_rd_w = {pin_sync_reg[7:4] & data_mask_w, 4'h0};

  // read mux, undefined and reserved bits answer zero
  logic [31:0] rdata_w;
  always_comb begin
    rdata_w = 32'h0;
    if (hit_data) rdata_w[7:0] = data_rd_w;
    if (hit_fs1) rdata_w[7:4] = fsel_one_reg;
    if (hit_fs2) rdata_w[7:4] = fsel_two_reg;
    if (hit_sens) rdata_w[7:6] = cfg_reg.sens;
    if (hit_both) rdata_w[7:6] = cfg_reg.both;
    if (hit_pol) rdata_w[7:6] = cfg_reg.pol;
    if (hit_en) rdata_w[7:6] = cfg_reg.en;
    if (hit_raw) rdata_w[7:6] = raw_mix_w;
    if (hit_mis) rdata_w[7:6] = mis_w;
  end

  // pin synchroniser; second stage only is read
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_meta_reg <= WIDE_PIN_RESET;
      pin_sync_reg <= WIDE_PIN_RESET;
      pin_prev_reg <= WIDE_PIN_RESET[7:6]; // idle high, no false edge after reset
    end else begin
      pin_meta_reg <= pin_i;
      pin_sync_reg <= pin_meta_reg;
      pin_prev_reg <= pin_sync_reg[7:6];
    end
  end

  // configuration registers, written via byte lane 0
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fsel_one_reg <= FSEL_ONE_RESET;
      fsel_two_reg <= FSEL_TWO_RESET;
      cfg_reg <= '0;
    end else if (wr_w) begin
      if (hit_fs1) fsel_one_reg <= req.dat[7:4];
      if (hit_fs2) fsel_two_reg <= req.dat[7:4];
      if (hit_sens) cfg_reg.sens <= req.dat[7:6];
      if (hit_both) cfg_reg.both <= req.dat[7:6];
      if (hit_pol) cfg_reg.pol <= req.dat[7:6];
      if (hit_en) cfg_reg.en <= req.dat[7:6];
    end
  end

  // latched edge requests and bus answer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      edge_flag_reg <= IRQ_CFG_RESET;
      ack_reg <= 1'b0;
      err_reg <= 1'b0;
      rdata_reg <= 32'h0;
    end else begin
      edge_flag_reg <= edge_flag_next;
      ack_reg <= access_w && hit_any;
      err_reg <= access_w && !hit_any;
      rdata_reg <= rdata_w;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_err_o = err_reg;
  assign wb_dat_o = rdata_reg;

  // assertions
  a_fsel_reset_alt: assert property (@(posedge clk_i) $fell(rst_i) |->
      $past(fsel_one_reg) == FSEL_ONE_RESET && $past(fsel_two_reg) == FSEL_TWO_RESET)
    else $error("function selects not at reset value");
  a_edge_clear_drops: assert property (@(posedge clk_i) disable iff (rst_i)
      wr_w && hit_clr && req.dat[6] && !edge_det_w[0] && !cfg_reg.sens[0] |=> !edge_flag_reg[0])
    else $error("clear did not drop edge request");
  a_level_follows_pin: assert property (@(posedge clk_i) disable iff (rst_i)
      cfg_reg.sens[1] |-> raw_mix_w[1] == (pin_sync_reg[7] == cfg_reg.pol[1]))
    else $error("level request does not follow pin");
  a_masked_from_raw: assert property (@(posedge clk_i) disable iff (rst_i)
      mis_w == (raw_mix_w & cfg_reg.en) && irq_o == |mis_w)
    else $error("masked status mismatch");
  a_rise_latches: assert property (@(posedge clk_i) disable iff (rst_i)
      !cfg_reg.sens[0] && !cfg_reg.both[0] && cfg_reg.pol[0] && rise_w[0] |=> edge_flag_reg[0])
    else $error("rising edge not latched");
  a_both_edges: assert property (@(posedge clk_i) disable iff (rst_i)
      !cfg_reg.sens[1] && cfg_reg.both[1] && fall_w[1] |=> edge_flag_reg[1])
    else $error("both-edge falling not latched");
  a_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_data_masked: assert property (@(posedge clk_i) disable iff (rst_i)
      access_w && hit_data && !req.we |=> wb_dat_o[7:4] == ($past(pin_sync_reg[7:4])
      & $past(data_mask_w)) && wb_dat_o[3:0] == 4'h0)
    else $error("data read ignores address mask");
  a_line_two_gpio: assert property (@(posedge clk_i) disable iff (rst_i)
      external_irq_line_two_o |-> cfg_reg.en[1] && !fsel_one_reg[3] && !fsel_two_reg[3])
    else $error("line two outside input mode");

endmodule // port_d_input_irq

// ### verif/pin_source_model.sv
// package pin source model: drives the eight port pins from the bench
`timescale 1ns/10ps
module pin_source_model (
  // clock
  input wire logic clk_i,
  // requested pin levels
  input wire logic [7:0] level_i,
  // package pins
  output logic [7:0] pin_o
);
  // pins change just after the clock edge, like a real source
  always_ff @(posedge clk_i) begin
    pin_o <= level_i;
  end
endmodule // pin_source_model

// ### verif/testbench.sv
// testbench: register bus scenarios, pin functions and interrupt detection
`timescale 1ns/10ps
module testbench;
  import port_d_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [3:0] sel = 4'h0;
  logic [11:0] adr = 12'h000;
  logic [31:0] wdat = 32'h0, rdat;
  logic ack, err, irq_o, line_one, line_two, touch_screen_interface, ty_p, tx_p, ty_m, tx_m;
  logic [3:0] conv, conv_en, touch_en;
  logic [7:0] lvl = 8'hFF, pins;
  int fail_count = 0, n_checks = 0, cycles = 0;
  always #25 clk_i = ~clk_i;
  pin_source_model i_pin_source_model (.clk_i(clk_i), .level_i(lvl), .pin_o(pins));
  port_d_input_irq i_port_d_input_irq (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_sel_i(sel), .wb_adr_i(adr), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err), .pin_i(pins),
    .converter_channels_upper_o(conv), .converter_route_en_o(conv_en),
    .touch_y_plus_o(ty_p), .touch_x_plus_o(tx_p), .touch_y_minus_o(ty_m),
    .touch_x_minus_o(tx_m), .touch_route_en_o(touch_en), .touch_screen_irq_o(touch_screen_interface),
    .external_irq_line_one_o(line_one), .external_irq_line_two_o(line_two), .irq_o(irq_o));
  // verdict and end of run
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // hang guard
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      final_report();
    end
  end
  // compare one value
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  // one classic cycle, held until ack or err is sampled
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= 4'hF;
    do @(negedge clk_i); while (!(ack === 1'b1 || err === 1'b1));
    q = rdat;
    e = err;
    @(posedge clk_i);
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    bus(1'b1, a, d, q, e);
  endtask
  task automatic rd(input string name, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    bus(1'b0, a, 32'h0, q, e);
    chk(name, exp, q);
  endtask
  // set pins and let synchroniser and edge flag settle
  task automatic set_pins(input logic [7:0] v);
    @(posedge clk_i);
    lvl <= v;
    repeat (6) @(posedge clk_i);
  endtask
  // reset values and data register mask lines
  task automatic t_reset_and_mask;
    rd("fs_one", OFS_FUNCTION_SELECT_ONE, 32'h0000_00F0);
    rd("fs_two", OFS_FUNCTION_SELECT_TWO, 32'h0000_0000);
    rd("sens", OFS_IRQ_SENSITIVITY_SELECT, 32'h0000_0000);
    rd("raw", OFS_IRQ_RAW_FLAGS, 32'h0000_0000);
    rd("data", OFS_PIN_INPUT_VALUE, 32'h0000_00F0);
    chk("conv_en", 32'(conv_en), 32'h0000_000F);
    set_pins(8'hA5);
    rd("data", OFS_PIN_INPUT_VALUE, 32'h0000_00A0);
    rd("data_bit7", 12'h200, 32'h0000_0080);
    rd("data_bit5", 12'h080, 32'h0000_0020);
    rd("data_bit6", 12'h100, 32'h0000_0000);
    chk("conv", 32'(conv), 32'h0000_000A);
  endtask
  // second alternate function routes to touch lines
  task automatic t_touch;
    wr(OFS_FUNCTION_SELECT_ONE, 32'h0);
    wr(OFS_FUNCTION_SELECT_TWO, 32'hF0);
    rd("fs_two", OFS_FUNCTION_SELECT_TWO, 32'h0000_00F0);
    chk("touch_en", 32'(touch_en), 32'h0000_000F);
    chk("conv_en", 32'(conv_en), 32'h0000_0000);
    chk("touch", 32'({ty_p, tx_p, ty_m, tx_m}), 32'h0000_000A);
    wr(OFS_FUNCTION_SELECT_TWO, 32'h0);
    chk("touch_en", 32'(touch_en), 32'h0000_0000);
  endtask
  // edge detection, polarity, both edges, masking and clear
  task automatic t_edges;
    wr(OFS_IRQ_CLEAR_STROBE, 32'hC0);
    wr(OFS_IRQ_ENABLE_MASK, 32'hC0);
    set_pins(8'h20);
    rd("raw", OFS_IRQ_RAW_FLAGS, 32'h0000_0080);
    rd("masked", OFS_IRQ_MASKED_FLAGS, 32'h0000_0080);
    chk("irq_lines", 32'({irq_o, line_two, line_one}), 32'h0000_0006);
    wr(OFS_IRQ_CLEAR_STROBE, 32'h80);
    rd("raw", OFS_IRQ_RAW_FLAGS, 32'h0000_0000);
    chk("irq", 32'(irq_o), 32'h0);
    set_pins(8'hA0);
    rd("raw", OFS_IRQ_RAW_FLAGS, 32'h0000_0000);
    wr(OFS_IRQ_BOTH_EDGE_SELECT, 32'h80);
    set_pins(8'h20);
    rd("raw", OFS_IRQ_RAW_FLAGS, 32'h0000_0080);
    wr(OFS_IRQ_CLEAR_STROBE, 32'h80);
    set_pins(8'hA0);
    rd("raw", OFS_IRQ_RAW_FLAGS, 32'h0000_0080);
    wr(OFS_IRQ_ENABLE_MASK, 32'h40);
    rd("masked", OFS_IRQ_MASKED_FLAGS, 32'h0000_0000);
    chk("irq", 32'(irq_o), 32'h0);
    wr(OFS_IRQ_CLEAR_STROBE, 32'hC0);
  endtask
  // level detection follows the pin and ignores clear
  task automatic t_level;
    wr(OFS_IRQ_SENSITIVITY_SELECT, 32'hC0);
    rd("sens", OFS_IRQ_SENSITIVITY_SELECT, 32'h0000_00C0);
    wr(OFS_IRQ_POLARITY_SELECT, 32'h40);
    wr(OFS_IRQ_ENABLE_MASK, 32'hC0);
    rd("raw", OFS_IRQ_RAW_FLAGS, 32'h0000_0000);
    set_pins(8'hE0);
    wr(OFS_IRQ_CLEAR_STROBE, 32'h40);
    rd("raw", OFS_IRQ_RAW_FLAGS, 32'h0000_0040);
    chk("irq_lines", 32'({irq_o, line_two, line_one}), 32'h0000_0005);
    wr(OFS_FUNCTION_SELECT_TWO, 32'hF0);
    chk("tsi_line_one", 32'({touch_screen_interface, line_one}), 32'h0000_0002);
    wr(OFS_FUNCTION_SELECT_TWO, 32'h0);
    set_pins(8'hA0);
    rd("raw", OFS_IRQ_RAW_FLAGS, 32'h0000_0000);
  endtask
  // unmapped place, read-only write and upper bits
  task automatic t_access;
    logic [31:0] q;
    logic e;
    bus(1'b0, 12'h400, 32'h0, q, e);
    chk("err", 32'(e), 32'h1);
    wr(OFS_IRQ_RAW_FLAGS, 32'hC0);
    rd("raw", OFS_IRQ_RAW_FLAGS, 32'h0000_0000);
    wr(OFS_FUNCTION_SELECT_ONE, 32'h0000_00F0);
    rd("fs_one", OFS_FUNCTION_SELECT_ONE, 32'h0000_00F0);
    chk("conv_en", 32'(conv_en), 32'h0000_0003);
  endtask
  // main sequence
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset_and_mask();
    t_touch();
    t_edges();
    t_level();
    t_access();
    final_report();
  end
endmodule // testbench
